/* File: rtl/scm_pkg.sv */
package scm_pkg;
  localparam int NUM_CH = 18;
  localparam int MS_W = 11;
  // figures in milliseconds, as printed
  localparam logic [MS_W-1:0] RF_LONG_MS = 11'd1350;
  localparam logic [MS_W-1:0] RF_SHORT_MS = 11'd850;
  localparam logic [MS_W-1:0] WD_SHORT_MS = 11'd1000;
  localparam logic [MS_W-1:0] WD_LONG_MS = 11'd1500;
  localparam logic [MS_W-1:0] BO_LONG_MS = 11'd400;
  localparam logic [MS_W-1:0] BO_SHORT_MS = 11'd80;
  // line thresholds in Vrms handed to the analog front end
  localparam logic [6:0] BO_ON_DROP_V = 7'd98;
  localparam logic [6:0] BO_ON_RESTORE_V = 7'd103;
  localparam logic [6:0] BO_OFF_DROP_V = 7'd92;
  localparam logic [6:0] BO_OFF_RESTORE_V = 7'd98;
  // clock period and the millisecond in picoseconds
  localparam int CLK_PERIOD_PS = 4000;
  localparam int MS_PS = 1000000000;
  localparam int MS_CYCLES_DEF = MS_PS / CLK_PERIOD_PS;
  localparam int TICK_W = 18;
endpackage : scm_pkg

/* File: rtl/scm_timer_if.sv */
`timescale 1ns/1ps
interface scm_timer_if;
  import scm_pkg::*;
  logic run;
  logic [MS_W-1:0] limit;
  logic expired;
  modport ctl (output run, output limit, input expired);
  modport tmr (input run, input limit, output expired);
endinterface : scm_timer_if

/* File: rtl/scm_ms_timer.sv */
`timescale 1ns/1ps
module scm_ms_timer import scm_pkg::*; (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ms_tick,
  scm_timer_if.tmr t
);
  logic [MS_W-1:0] count;
  wire at_limit = (count >= t.limit);

  // the count restarts whenever run drops, so a gap of one cycle rearms it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      t.expired <= 1'b0;
    end else begin
      if (!t.run)
        count <= '0;
      else if (ms_tick && !at_limit)
        count <= count + 11'h001;
      t.expired <= t.run && at_limit;
    end
  end
endmodule : scm_ms_timer

/* File: rtl/scm_monitor.sv */
`timescale 1ns/1ps
module scm_monitor import scm_pkg::*; #(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [NUM_CH-1:0] field_green,
  input wire logic [NUM_CH-1:0] field_yellow,
  input wire logic [NUM_CH-1:0] field_red,
  input wire logic red_enable,
  input wire logic relay_common_sense,
  input wire logic card_present,
  input wire logic conflict_event,
  input wire logic dual_event,
  input wire logic clearance_event,
  input wire logic [NUM_CH-1:0] event_channels,
  input wire logic diag_fail,
  input wire logic dc_supply_ok,
  input wire logic watchdog_in,
  input wire logic ac_below_dropout,
  input wire logic ac_above_restore,
  input wire logic [NUM_CH-1:0] red_fail_chan_enable,
  input wire logic sw_red_fail_long,
  input wire logic sw_watchdog_short,
  input wire logic opt_brownout,
  input wire logic opt_watchdog_latch,
  input wire logic jmp_relay_polarity,
  input wire logic front_reset,
  input wire logic remote_reset,
  output logic power_good_indicator,
  output logic dc_supply_fault_indicator,
  output logic watchdog_fault_indicator,
  output logic conflict_indicator,
  output logic red_fail_indicator,
  output logic dual_indicator,
  output logic clearance_indicator,
  output logic card_missing_indicator,
  output logic monitor_fail_indicator,
  output logic [NUM_CH-1:0] chan_green_ind,
  output logic [NUM_CH-1:0] chan_yellow_ind,
  output logic [NUM_CH-1:0] chan_red_ind,
  output logic [NUM_CH-1:0] chan_fault_ind,
  output logic fault_mode,
  output logic [6:0] dropout_threshold_vrms,
  output logic [6:0] restore_threshold_vrms
);
  // option inputs sampled into registers
  logic sw_rf_q, sw_wd_q, opt_bo_q, opt_wl_q, jmp_q, sense_q, card_q, wd_in_q;
  logic [NUM_CH-1:0] rf_en_q;
  logic [TICK_W-1:0] tick_cnt;
  logic ms_tick;
  logic power_fault;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {sw_rf_q, sw_wd_q, opt_bo_q, opt_wl_q, jmp_q} <= 5'h00;
      sense_q <= 1'b0;
      card_q <= 1'b1;
      wd_in_q <= 1'b0;
      rf_en_q <= '0;
    end else begin
      {sw_rf_q, sw_wd_q, opt_bo_q, opt_wl_q, jmp_q} <= {sw_red_fail_long, sw_watchdog_short,
        opt_brownout, opt_watchdog_latch, jmp_relay_polarity};
      sense_q <= relay_common_sense;
      card_q <= card_present;
      wd_in_q <= watchdog_in;
      rf_en_q <= red_fail_chan_enable;
    end
  end

  // one shared millisecond tick
  wire tick_wrap = (tick_cnt == TICK_W'(MS_CYCLES - 1));
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= '0;
      ms_tick <= 1'b0;
    end else begin
      tick_cnt <= tick_wrap ? '0 : tick_cnt + 18'h00001;
      ms_tick <= tick_wrap;
    end
  end

  wire relay_active = sense_q ^ jmp_q;
  wire reset_req = front_reset | remote_reset;
  wire [NUM_CH-1:0] chan_dark = ~(field_green | field_yellow | field_red);
  wire rf_allowed = red_enable && !relay_active && !power_fault;
  wire [MS_W-1:0] rf_limit = sw_rf_q ? RF_LONG_MS : RF_SHORT_MS;
  wire [MS_W-1:0] wd_limit = sw_wd_q ? WD_SHORT_MS : WD_LONG_MS;
  wire [MS_W-1:0] bo_limit = opt_bo_q ? BO_LONG_MS : BO_SHORT_MS;

  scm_timer_if rf_if [NUM_CH] ();
  scm_timer_if wd_if ();
  scm_timer_if bo_if ();
  logic [NUM_CH-1:0] rf_exp;
  logic [NUM_CH-1:0] rf_run;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_rf
    assign rf_run[c] = rf_allowed && rf_en_q[c] && chan_dark[c] && !fault_mode;
    assign rf_if[c].run = rf_run[c];
    assign rf_if[c].limit = rf_limit;
    assign rf_exp[c] = rf_if[c].expired;
    scm_ms_timer u_rf (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .ms_tick(ms_tick),
      .t(rf_if[c])
    );
  end

  // the watchdog timer restarts on every change of the controller's output
  assign wd_if.run = (watchdog_in == wd_in_q) && !power_fault;
  assign wd_if.limit = wd_limit;
  scm_ms_timer u_wd (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ms_tick(ms_tick),
    .t(wd_if)
  );

  assign bo_if.run = ac_below_dropout && !power_fault;
  assign bo_if.limit = bo_limit;
  scm_ms_timer u_bo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ms_tick(ms_tick),
    .t(bo_if)
  );

  wire bo_event = bo_if.expired;
  wire wd_set = wd_if.expired;
  wire rf_set = |rf_exp;
  wire card_set = !card_q;
  wire clr_ok = reset_req && card_q;
  wire any_set = wd_set | rf_set | card_set | conflict_event | dual_event | clearance_event
    | !dc_supply_ok | diag_fail;
  // without the latch a power event drops the watchdog fault; a new expiry still wins
  wire wd_clr = clr_ok || (bo_event && !opt_wl_q);
  wire [NUM_CH-1:0] new_chans = conflict_event ? (field_green | field_yellow) :
    (dual_event || clearance_event) ? event_channels : rf_exp;
  wire chan_set = conflict_event | dual_event | clearance_event | rf_set;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_fault <= 1'b0;
    end else if (bo_event) begin
      power_fault <= 1'b1;
    end else if (ac_above_restore && !ac_below_dropout) begin
      power_fault <= 1'b0;
    end
  end

  // fault flags: a set in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_mode <= 1'b0;
      watchdog_fault_indicator <= 1'b0;
      red_fail_indicator <= 1'b0;
      conflict_indicator <= 1'b0;
      dual_indicator <= 1'b0;
      clearance_indicator <= 1'b0;
      card_missing_indicator <= 1'b0;
      dc_supply_fault_indicator <= 1'b0;
      monitor_fail_indicator <= 1'b0;
      chan_fault_ind <= '0;
    end else begin
      fault_mode <= (fault_mode && !clr_ok) || any_set;
      watchdog_fault_indicator <= (watchdog_fault_indicator && !wd_clr) || wd_set;
      red_fail_indicator <= (red_fail_indicator && !clr_ok) || rf_set;
      conflict_indicator <= (conflict_indicator && !clr_ok) || conflict_event;
      dual_indicator <= (dual_indicator && !clr_ok) || dual_event;
      clearance_indicator <= (clearance_indicator && !clr_ok) || clearance_event;
      card_missing_indicator <= (card_missing_indicator && !clr_ok) || card_set;
      dc_supply_fault_indicator <= (dc_supply_fault_indicator && !clr_ok) || !dc_supply_ok;
      monitor_fail_indicator <= (monitor_fail_indicator && !clr_ok) || diag_fail;
      // only the first fault's channels are kept; a fault landing on the clear still records
      if (chan_set && (!fault_mode || clr_ok))
        chan_fault_ind <= new_chans;
      else if (clr_ok)
        chan_fault_ind <= '0;
    end
  end

  // channel status follows the field until fault mode, then freezes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_green_ind <= '0;
      chan_yellow_ind <= '0;
      chan_red_ind <= '0;
      power_good_indicator <= 1'b0;
      dropout_threshold_vrms <= BO_OFF_DROP_V;
      restore_threshold_vrms <= BO_OFF_RESTORE_V;
    end else begin
      if (!fault_mode) begin
        chan_green_ind <= field_green;
        chan_yellow_ind <= field_yellow;
        chan_red_ind <= field_red;
      end
      power_good_indicator <= !power_fault;
      dropout_threshold_vrms <= opt_bo_q ? BO_ON_DROP_V : BO_OFF_DROP_V;
      restore_threshold_vrms <= opt_bo_q ? BO_ON_RESTORE_V : BO_OFF_RESTORE_V;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_card_back_reset;
    card_q && reset_req;
  endsequence

  a_card_fault_set: assert property (!card_q |=> card_missing_indicator && fault_mode)
    else $error("missing card did not raise fault");
  a_card_clear_gate: assert property ($fell(card_missing_indicator) |-> $past(card_q && reset_req))
    else $error("card fault cleared without card and reset");
  a_fault_hold: assert property (fault_mode && !reset_req |=> fault_mode)
    else $error("fault mode dropped without reset");
  a_fault_release: assert property (s_card_back_reset ##0 !any_set |=> !fault_mode)
    else $error("reset did not leave fault mode");
  a_leds_frozen: assert property (fault_mode |=> $stable(chan_green_ind) && $stable(chan_red_ind))
    else $error("channel status changed in fault mode");
  a_redfail_gated: assert property (relay_active |=> rf_exp == '0)
    else $error("red fail timing ran with relay common active");
  a_redfail_flag: assert property (rf_set |=> red_fail_indicator && chan_fault_ind != '0)
    else $error("red fail expiry not recorded");
  a_wd_unlatch: assert property (bo_event && !opt_wl_q && !wd_set |=> !watchdog_fault_indicator)
    else $error("unlatched watchdog fault survived power event");
  a_wd_latched: assert property (watchdog_fault_indicator && opt_wl_q && !reset_req |=>
    watchdog_fault_indicator)
    else $error("latched watchdog fault lost");
  a_thresh_select: assert property (opt_bo_q |=> dropout_threshold_vrms == BO_ON_DROP_V
    && restore_threshold_vrms == BO_ON_RESTORE_V)
    else $error("brown-out thresholds wrong with option present");
  a_thresh_plain: assert property (!opt_bo_q |=> dropout_threshold_vrms == BO_OFF_DROP_V)
    else $error("brown-out thresholds wrong with option absent");
  a_rf_limit_sel: assert property (rf_if[0].limit == (sw_rf_q ? 11'd1350 : 11'd850))
    else $error("red fail time selection wrong");
  a_wd_limit_sel: assert property (wd_if.limit == (sw_wd_q ? 11'd1000 : 11'd1500))
    else $error("watchdog time selection wrong");
endmodule : scm_monitor

/* File: sim/scm_ctrl_model.sv */
`timescale 1ns/1ps
module scm_ctrl_model (
  input wire logic sys_clk,
  input wire logic alive,
  output logic watchdog_in
);
  logic [2:0] div = 3'h0;
  initial watchdog_in = 1'b0;
  // a live controller toggles every 8 clocks; dropping alive models a hung controller
  always @(posedge sys_clk) begin
    div <= div + 3'h1;
    if (alive && div == 3'h7) watchdog_in <= ~watchdog_in;
  end
endmodule : scm_ctrl_model

/* File: sim/signal_conflict_monitor_options_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin bad_count++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, gt); end end
module signal_conflict_monitor_options_tb import scm_pkg::*; ;
  localparam int MSC = 4;
  typedef struct {logic bo; logic [17:0] g, y, r; logic [6:0] dv, rv;} scm_row_s;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [NUM_CH-1:0] fg, fy, fr, ev_ch, rf_en, cg, cy, cr, cf;
  logic red_enable, relay, card, conflict_ev, dual_ev, clr_ev, diag, dc_ok, alive, wd_in;
  logic ac_low, ac_high, sw_rf, sw_wd, opt_bo, opt_wl, jmp, front_rst, remote_rst;
  logic pg, dcf, wdf, cfi, rfi, dui, cli, cmi, mfi, fmode;
  logic [6:0] drop_v, rest_v;
  int bad_count = 0;
  int n_compared = 0;
  scm_row_s rows[3] = '{
    '{1'b1, 18'h00001, 18'h20000, 18'h3fffe, BO_ON_DROP_V, BO_ON_RESTORE_V},
    '{1'b0, 18'h2aaaa, 18'h15555, 18'h00000, BO_OFF_DROP_V, BO_OFF_RESTORE_V},
    '{1'b1, 18'h3ffff, 18'h00000, 18'h12345, BO_ON_DROP_V, BO_ON_RESTORE_V}};
  scm_ctrl_model u_scm_ctrl_model (.sys_clk(sys_clk), .alive(alive), .watchdog_in(wd_in));
  scm_monitor #(.MS_CYCLES(MSC)) u_scm_monitor (.sys_clk(sys_clk), .arst_n(arst_n),
    .field_green(fg), .field_yellow(fy), .field_red(fr), .red_enable(red_enable),
    .relay_common_sense(relay), .card_present(card), .conflict_event(conflict_ev),
    .dual_event(dual_ev), .clearance_event(clr_ev), .event_channels(ev_ch),
    .diag_fail(diag), .dc_supply_ok(dc_ok), .watchdog_in(wd_in), .ac_below_dropout(ac_low),
    .ac_above_restore(ac_high), .red_fail_chan_enable(rf_en), .sw_red_fail_long(sw_rf),
    .sw_watchdog_short(sw_wd), .opt_brownout(opt_bo), .opt_watchdog_latch(opt_wl),
    .jmp_relay_polarity(jmp), .front_reset(front_rst), .remote_reset(remote_rst),
    .power_good_indicator(pg), .dc_supply_fault_indicator(dcf),
    .watchdog_fault_indicator(wdf), .conflict_indicator(cfi), .red_fail_indicator(rfi),
    .dual_indicator(dui), .clearance_indicator(cli), .card_missing_indicator(cmi),
    .monitor_fail_indicator(mfi), .chan_green_ind(cg), .chan_yellow_ind(cy),
    .chan_red_ind(cr), .chan_fault_ind(cf), .fault_mode(fmode),
    .dropout_threshold_vrms(drop_v), .restore_threshold_vrms(rest_v));
  always #2 sys_clk = ~sys_clk;
  // inputs move 1 ns after the edge so the design never races the bench
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic ms(input int n);
    cyc(n * MSC);
  endtask : ms
  task automatic clr;
    remote_rst = 1'b1;
    cyc(1);
    remote_rst = 1'b0;
    cyc(1);
  endtask : clr
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial begin
    {fg, fy, fr, ev_ch, rf_en} = '0;
    {red_enable, relay, conflict_ev, dual_ev, clr_ev, diag, ac_low} = '0;
    {sw_rf, sw_wd, opt_bo, opt_wl, jmp, front_rst, remote_rst} = '0;
    {card, dc_ok, ac_high, alive} = '1;
    cyc(4);
    `CHK("drop_v rst", BO_OFF_DROP_V, drop_v)
    `CHK("pg rst", 1'b0, pg)
    arst_n = 1'b1;
    cyc(2);
    `CHK("pg", 1'b1, pg)
    foreach (rows[i]) begin
      {opt_bo, fg, fy, fr} = {rows[i].bo, rows[i].g, rows[i].y, rows[i].r};
      cyc(3);
      `CHK("drop_v", rows[i].dv, drop_v)
      `CHK("restore_v", rows[i].rv, rest_v)
      `CHK("leds", {rows[i].g, rows[i].y, rows[i].r}, {cg, cy, cr})
    end
    {fg, fy, fr} = {18'h00005, 18'h00100, 18'h0};
    cyc(2);
    conflict_ev = 1'b1;
    cyc(1);
    conflict_ev = 1'b0;
    `CHK("conflict", 2'b11, {cfi, fmode})
    `CHK("conflict chans", 18'h00105, cf)
    fg = '0;
    cyc(3);
    `CHK("frozen green", 18'h00005, cg)
    front_rst = 1'b1;
    cyc(1);
    front_rst = 1'b0;
    cyc(1);
    `CHK("front reset", 2'b00, {cfi, fmode})
    {ev_ch, dual_ev} = {18'h30000, 1'b1};
    cyc(1);
    {ev_ch, dual_ev, clr_ev} = {18'h00003, 1'b0, 1'b1};
    cyc(1);
    {clr_ev, diag, dc_ok} = 3'b010;
    cyc(2);
    `CHK("dual clr flags", 4'hf, {dui, cli, mfi, dcf})
    `CHK("first fault chans", 18'h30000, cf)
    {diag, dc_ok, card, front_rst} = 4'b0101;
    cyc(3);
    `CHK("card out", 2'b11, {cmi, fmode})
    {card, front_rst} = 2'b10;
    cyc(3);
    `CHK("reset while out", 1'b1, fmode)
    clr;
    `CHK("remote reset", 4'h0, {cmi, dui, mfi, fmode})
    // second pass latches and uses the long watchdog time
    for (int l = 0; l < 2; l++) begin
      {opt_wl, sw_wd, alive} = {l[0], !l[0], 1'b0};
      cyc(2);
      ms(int'(l ? WD_LONG_MS : WD_SHORT_MS) - 4);
      `CHK("wd early", 1'b0, wdf)
      ms(6);
      `CHK("wd fault", 2'b11, {wdf, fmode})
      {alive, ac_low, ac_high, opt_bo} = 4'b1100;
      ms(int'(BO_SHORT_MS) + 2);
      `CHK("brownout pg", 1'b0, pg)
      `CHK("wd after bo", l[0], wdf)
      {ac_low, ac_high} = 2'b01;
      cyc(4);
      `CHK("pg back", 1'b1, pg)
      clr;
    end
    {fg, fy, fr, rf_en, red_enable, jmp, relay} = {54'h0, 18'h00001, 3'b110};
    ms(900);
    `CHK("relay active inv", 1'b0, rfi)
    relay = 1'b1;
    ms(int'(RF_SHORT_MS) - 4);
    `CHK("rf early", 1'b0, rfi)
    ms(6);
    `CHK("rf fault", {1'b1, 18'h00001}, {rfi, cf})
    clr;
    jmp = 1'b0;
    ms(900);
    `CHK("relay active", 1'b0, rfi)
    {relay, sw_rf} = 2'b01;
    ms(int'(RF_LONG_MS) - 4);
    `CHK("rf long early", 1'b0, rfi)
    ms(6);
    `CHK("rf long", 1'b1, rfi)
    // a new fault in the very cycle of a reset must win and record its channels
    fg = 18'h00003;
    cyc(1);
    {conflict_ev, remote_rst} = 2'b11;
    cyc(1);
    {conflict_ev, remote_rst} = 2'b00;
    `CHK("event on clear", {3'b101, 18'h00003}, {cfi, rfi, fmode, cf})
    {arst_n, opt_bo} = 2'b01;
    cyc(2);
    `CHK("mid reset", {3'b000, BO_OFF_DROP_V}, {cfi, fmode, pg, drop_v})
    `CHK("mid reset chans", 18'h00000, cf)
    arst_n = 1'b1;
    cyc(2);
    `CHK("after reset", {1'b1, BO_ON_DROP_V, BO_ON_RESTORE_V}, {pg, drop_v, rest_v})
    {ac_low, ac_high} = 2'b10;
    ms(int'(BO_LONG_MS) - 4);
    `CHK("bo long early", 1'b1, pg)
    ms(6);
    `CHK("bo long", 1'b0, pg)
    test_done();
  end
endmodule : signal_conflict_monitor_options_tb
